// File: core/rtc_bank_regs.vh
// register offsets, field positions, reset values and timing for the rtc bank
`ifndef RTC_BANK_REGS_VH
`define RTC_BANK_REGS_VH

// register offsets
`define OFS_SEC        7'h00
`define OFS_SEC_ALM    7'h01
`define OFS_MIN        7'h02
`define OFS_MIN_ALM    7'h03
`define OFS_HR         7'h04
`define OFS_HR_ALM     7'h05
`define OFS_WDAY       7'h06
`define OFS_DATE       7'h07
`define OFS_MON        7'h08
`define OFS_YEAR       7'h09
`define OFS_CTRL_A     7'h0A
`define OFS_CTRL_B     7'h0B
`define OFS_FLAGS      7'h0C
`define OFS_STATUS     7'h0D
`define OFS_CENTURY    7'h32

// mode_enable_control fields
`define B_SET          7
`define B_PIE          6
`define B_AIE          5
`define B_UIE          4
`define B_WAVE         3
`define B_ENC          2
`define B_H24          1
`define B_DSE          0

// divider control patterns
`define DV_RUN         3'b010
`define DV_OFF         3'b000

// reset values
`define RST_CTRL_A     7'h00
`define RST_CTRL_B     8'h00
`define RST_TIME       8'h00
`define RST_ONE        8'h01

// timing and alarm don't-care code
`define OSC_HZ         32'd32768
`define DIV_START_HALF 15'h4000
`define UIP_LEAD_TICKS 15'h0008
`define DONT_CARE      2'b11

`endif

// File: core/rtc_time_calendar_alarm_bank.v
// time, calendar and alarm register bank with byte port and second counter
`timescale 1ns/1ps
// Behaviour
// RULE1: after supply returns with clock running, refuse bus access for recovery time
// RULE2: if oscillator off at supply return, turn it on, allow access at once
// RULE3: all ten time and alarm bytes share one encoding, binary or decimal
// RULE4: weekday advances at midnight through 1..7, 1 is Sunday
// RULE5: date rolls at true month end, short months and leap February included
// RULE6: software sets update inhibit before writing, clears it after encoding bit
// RULE7: software writes bytes in chosen encoding; device updates in that encoding
// RULE8: software reinitialises time after encoding change, hours after format change
// RULE9: in 12-hour format bit 7 of hour bytes means PM when set
// RULE10: bytes always accessible; once a second advance time and test alarm
// RULE11: reads during an update may be inconsistent; software must cope
// RULE12: matching hour, minute, second alarm raises alarm flag daily
// RULE13: alarm byte with two top bits set matches any value
// RULE14: don't-care bytes give hourly, per-minute or per-second alarms
// RULE15: software writes reserved zero bits as zero for fixed alarms
// RULE16: all 128 bytes read/write except flags, status, busy bit, seconds top
// RULE17: decimal mode places ten bytes at 00..09 with decimal ranges
// RULE18: binary mode holds the same ten bytes as plain binary values
// RULE19: device may clear reserved zero bits on update, not in seconds
// RULE20: invalid written time values give undefined counting
// RULE21: century variant keeps decimal century at 32H, else plain memory
// RULE22: only divider pattern 010 counts; 11x holds chain; first update 500ms
// RULE23: update inhibit at 1 suppresses updates; at 0 counts advance per second
// RULE24: encoding bit 1 means binary, 0 decimal; device never changes it
// RULE25: format bit 1 means 24-hour, 0 means 12-hour
// RULE26: one-second tick from last stage of 32.768kHz binary divider
`include "rtc_bank_regs.vh"

module rtc_time_calendar_alarm_bank
#(
  parameter CLK_HZ      = 250000000,
  parameter REC_TIME_MS = 200,
  parameter REC_CYCLES  = REC_TIME_MS * (CLK_HZ / 1000),
  parameter HAS_CENTURY = 1
)
(
  // clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // supply and backup status pins
  input  wire       vcc_ok,
  input  wire       batt_ok,
  // byte register port
  input  wire [6:0] bus_addr,
  input  wire       bus_wr,
  input  wire       bus_rd,
  input  wire [7:0] bus_wdata,
  output reg  [7:0] bus_rdata_r,
  output reg        bus_ready_r,
  // status
  output reg        irq_flag_r,
  output reg        second_tick_r
);

  // ==========================================================
  // helper functions
  function [7:0] to_bin;
    input [7:0] v;
    input       bin;
    begin
      to_bin = bin ? v : ({4'h0, v[7:4]} * 8'd10 + {4'h0, v[3:0]});
    end
  endfunction

  function [7:0] from_bin;
    input [7:0] b;
    input       bin;
    reg   [7:0] q;
    reg   [7:0] r;
    begin
      q = b / 8'd10;
      r = b - q * 8'd10;
      from_bin = bin ? b : {q[3:0], r[3:0]};
    end
  endfunction

  // RULE13: don't-care code
  function alarm_hit;
    input [7:0] alm;
    input [7:0] cur;
    begin
      alarm_hit = (alm[7:6] == `DONT_CARE) || (alm == cur);
    end
  endfunction

  // ==========================================================
  // storage
  reg  [7:0] sec_r, sec_alm_r, min_r, min_alm_r, hr_r, hr_alm_r;
  reg  [7:0] wday_r, date_r, mon_r, year_r, cent_r;
  reg  [6:0] ctrl_a_r;
  reg  [7:0] ctrl_b_r;
  reg        pf_r, af_r, uf_r, uip_r;
  reg  [7:0] ram [0:127];

  // ==========================================================
  // pin synchronisers
  reg  [1:0] vcc_sync_r;
  reg  [1:0] batt_sync_r;
  reg        vcc_prev_r;

  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      vcc_sync_r  <= 2'b00;
      batt_sync_r <= 2'b00;
      vcc_prev_r  <= 1'b0;
    end
    else
    begin
      vcc_sync_r  <= {vcc_sync_r[0], vcc_ok};
      batt_sync_r <= {batt_sync_r[0], batt_ok};
      vcc_prev_r  <= vcc_sync_r[1];
    end

  wire vcc_up   = vcc_sync_r[1];
  wire vcc_rise = vcc_up & ~vcc_prev_r;

  // ==========================================================
  // power-up recovery
  wire [2:0] dv        = ctrl_a_r[6:4];
  wire       osc_run   = (dv == `DV_RUN);
  wire       chain_hold = (dv[2:1] == 2'b11);
  wire       osc_on    = osc_run | chain_hold;
  reg [31:0] rec_cnt_r;
  // rise cycle itself is refused, else one access slips in
  wire       bus_ok    = vcc_up && (rec_cnt_r == 32'h0000_0000) &&
                         !(vcc_rise && osc_run);

  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      rec_cnt_r <= 32'h0000_0000;
    else if (!vcc_up)
      rec_cnt_r <= 32'h0000_0000;
    // RULE1: recovery wait
    else if (vcc_rise && osc_run)
      rec_cnt_r <= REC_CYCLES;
    else if (rec_cnt_r != 32'h0000_0000)
      rec_cnt_r <= rec_cnt_r - 32'h0000_0001;

  // ==========================================================
  // 32.768khz enable and 15-stage divider
  // fractional accumulator keeps long-term rate exact at any sys_clk of 32768 Hz or more
  reg  [31:0] frac_r;
  wire [31:0] frac_sum = frac_r + `OSC_HZ;
  wire        osc_tick = osc_on && (frac_sum >= CLK_HZ);
  reg  [14:0] div_r;
  wire        set_bit  = ctrl_b_r[`B_SET];
  // RULE26: last stage overflow
  wire        sec_wrap = osc_tick && osc_run && (div_r == 15'h7FFF);
  // RULE23: inhibit blocks transfer
  wire        upd      = sec_wrap && !set_bit;

  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      frac_r <= 32'h0000_0000;
      div_r  <= `DIV_START_HALF;
      uip_r  <= 1'b0;
    end
    else
    begin
      if (osc_on)
        frac_r <= osc_tick ? frac_sum - CLK_HZ : frac_sum;
      // RULE22: held chain restarts half way
      if (!osc_run)
        div_r <= `DIV_START_HALF;
      else if (osc_tick)
        div_r <= div_r + 15'h0001;
      // RULE11: busy flag before update
      uip_r <= osc_run && !set_bit &&
               (div_r >= (15'h7FFF - `UIP_LEAD_TICKS));
    end

  // ==========================================================
  // next time values
  // RULE7: updates follow encoding
  wire       bin = ctrl_b_r[`B_ENC];
  // RULE25: format bit picks 24h
  wire       h24 = ctrl_b_r[`B_H24];
  reg  [7:0] s_b, m_b, h_b, d_b, mo_b, y_b, c_b, dim;
  reg  [7:0] sec_nxt, min_nxt, hr_nxt, wday_nxt, date_nxt;
  reg  [7:0] mon_nxt, year_nxt, cent_nxt;
  reg        c_min, c_hr, c_day, c_mon, c_year, pm_nxt;

  always @*
  begin
    // RULE3: one encoding for the ten time and alarm bytes; century always decimal
    // RULE24: encoding bit picks binary
    s_b  = to_bin({1'b0, sec_r[6:0]}, bin);
    m_b  = to_bin(min_r, bin);
    h_b  = to_bin({1'b0, hr_r[6:0]}, bin);
    d_b  = to_bin(date_r, bin);
    mo_b = to_bin(mon_r, bin);
    y_b  = to_bin(year_r, bin);
    c_b  = to_bin(cent_r, 1'b0);
    c_min = (s_b == 8'd59);
    c_hr  = c_min && (m_b == 8'd59);
    pm_nxt = hr_r[7];
    c_day = 1'b0;
    if (h24)
    begin
      c_day = c_hr && (h_b == 8'd23);
      hr_nxt = from_bin(c_day ? 8'd0 : h_b + {7'h00, c_hr}, bin);
    end
    else
    begin
      // RULE9: pm bit in 12-hour mode
      if (c_hr && h_b == 8'd11)
      begin
        pm_nxt = ~hr_r[7];
        c_day  = hr_r[7];
      end
      hr_nxt = from_bin((c_hr && h_b == 8'd12) ? 8'd1 :
                        h_b + {7'h00, c_hr}, bin);
      hr_nxt = {pm_nxt, hr_nxt[6:0]};
    end
    // RULE5: month length with leap years
    case (mo_b)
      8'd2:    dim = (y_b[1:0] == 2'b00) ? 8'd29 : 8'd28;
      8'd4,
      8'd6,
      8'd9,
      8'd11:   dim = 8'd30;
      default: dim = 8'd31;
    endcase
    c_mon  = c_day && (d_b >= dim);
    c_year = c_mon && (mo_b == 8'd12);
    // RULE19: reserved bits rewritten as zero
    sec_nxt  = from_bin(c_min ? 8'd0 : s_b + 8'd1, bin);
    min_nxt  = from_bin(c_hr ? 8'd0 : (c_min ? m_b + 8'd1 : m_b), bin);
    // RULE4: weekday 1..7
    wday_nxt = c_day ? ((wday_r[2:0] == 3'd7) ? 8'h01 :
                       {5'h00, wday_r[2:0] + 3'd1}) : wday_r;
    date_nxt = from_bin(c_mon ? 8'd1 : d_b + {7'h00, c_day}, bin);
    mon_nxt  = from_bin(c_year ? 8'd1 : mo_b + {7'h00, c_mon}, bin);
    year_nxt = from_bin((c_year && y_b == 8'd99) ? 8'd0 :
                        y_b + {7'h00, c_year}, bin);
    // RULE21: decimal century counter
    cent_nxt = from_bin((c_year && y_b == 8'd99) ?
                        ((c_b == 8'd99) ? 8'd0 : c_b + 8'd1) : c_b, 1'b0);
  end

  // RULE12: alarm test on new time
  // RULE14: masked bytes widen match
  wire alarm_now = alarm_hit(sec_alm_r, sec_nxt) &&
                   alarm_hit(min_alm_r, min_nxt) &&
                   alarm_hit(hr_alm_r, hr_nxt);

  // ==========================================================
  // register writes and second update
  wire wr_ok   = bus_wr && bus_ok;
  wire rd_ok   = bus_rd && bus_ok;
  wire rd_flag = rd_ok && (bus_addr == `OFS_FLAGS);
  wire cent_hw = (HAS_CENTURY != 0);

  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      sec_r <= `RST_TIME;  sec_alm_r <= `RST_TIME;
      min_r <= `RST_TIME;  min_alm_r <= `RST_TIME;
      hr_r  <= `RST_TIME;  hr_alm_r  <= `RST_TIME;
      wday_r <= `RST_ONE;  date_r    <= `RST_ONE;
      mon_r  <= `RST_ONE;  year_r    <= `RST_TIME;
      cent_r <= `RST_TIME;
      ctrl_a_r <= `RST_CTRL_A;
      ctrl_b_r <= `RST_CTRL_B;
      pf_r <= 1'b0;
      af_r <= 1'b0;
      uf_r <= 1'b0;
    end
    else
    begin
      // RULE10: whole set advances in one cycle
      if (upd)
      begin
        sec_r  <= sec_nxt;
        min_r  <= min_nxt;
        hr_r   <= hr_nxt;
        wday_r <= wday_nxt;
        date_r <= date_nxt;
        mon_r  <= mon_nxt;
        year_r <= year_nxt;
        cent_r <= cent_nxt;
      end
      // RULE2: power-up turns oscillator on
      if (vcc_rise && !osc_on)
        ctrl_a_r[6:4] <= `DV_RUN;
      // RULE16: read-only bytes and bits
      if (wr_ok)
        // RULE20: written values unchecked
        case (bus_addr)
          `OFS_SEC:     sec_r     <= {1'b0, bus_wdata[6:0]};
          `OFS_SEC_ALM: sec_alm_r <= bus_wdata;
          `OFS_MIN:     min_r     <= bus_wdata;
          `OFS_MIN_ALM: min_alm_r <= bus_wdata;
          `OFS_HR:      hr_r      <= bus_wdata;
          `OFS_HR_ALM:  hr_alm_r  <= bus_wdata;
          `OFS_WDAY:    wday_r    <= bus_wdata;
          `OFS_DATE:    date_r    <= bus_wdata;
          `OFS_MON:     mon_r     <= bus_wdata;
          `OFS_YEAR:    year_r    <= bus_wdata;
          `OFS_CTRL_A:  ctrl_a_r  <= bus_wdata[6:0];
          `OFS_CTRL_B:
          begin
            ctrl_b_r <= bus_wdata;
            // any write with inhibit set also drops update-end enable
            if (bus_wdata[`B_SET])
              ctrl_b_r[`B_UIE] <= 1'b0;
          end
          `OFS_CENTURY: cent_r    <= bus_wdata;
          default:      ;
        endcase
      // flag read clears; a same-cycle event wins
      if (rd_flag)
      begin
        pf_r <= 1'b0;
        af_r <= 1'b0;
        uf_r <= 1'b0;
      end
      if (upd)
      begin
        uf_r <= 1'b1;
        if (alarm_now)
          af_r <= 1'b1;
      end
    end

  // general-purpose memory; time bytes shadow their slots
  always @(posedge sys_clk)
    if (wr_ok)
      ram[bus_addr] <= bus_wdata;

  // ==========================================================
  // read mux
  wire       any_irq_flag = (pf_r & ctrl_b_r[`B_PIE]) | (af_r & ctrl_b_r[`B_AIE]) |
                    (uf_r & ctrl_b_r[`B_UIE]);
  reg  [7:0] rd_mux;

  // RULE17: decimal layout at 00..09
  // RULE18: binary layout same slots
  always @*
  begin
    case (bus_addr)
      `OFS_SEC:     rd_mux = {1'b0, sec_r[6:0]};
      `OFS_SEC_ALM: rd_mux = sec_alm_r;
      `OFS_MIN:     rd_mux = min_r;
      `OFS_MIN_ALM: rd_mux = min_alm_r;
      `OFS_HR:      rd_mux = hr_r;
      `OFS_HR_ALM:  rd_mux = hr_alm_r;
      `OFS_WDAY:    rd_mux = wday_r;
      `OFS_DATE:    rd_mux = date_r;
      `OFS_MON:     rd_mux = mon_r;
      `OFS_YEAR:    rd_mux = year_r;
      `OFS_CTRL_A:  rd_mux = {uip_r, ctrl_a_r};
      `OFS_CTRL_B:  rd_mux = ctrl_b_r;
      `OFS_FLAGS:   rd_mux = {any_irq_flag, pf_r, af_r, uf_r, 4'h0};
      `OFS_STATUS:  rd_mux = {batt_sync_r[1], 7'h00};
      `OFS_CENTURY: rd_mux = cent_hw ? cent_r : ram[bus_addr];
      default:      rd_mux = ram[bus_addr];
    endcase
  end

  // ==========================================================
  // registered outputs
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      bus_rdata_r   <= 8'h00;
      bus_ready_r   <= 1'b0;
      irq_flag_r    <= 1'b0;
      second_tick_r <= 1'b0;
    end
    else
    begin
      // refused reads return zero
      bus_rdata_r   <= rd_ok ? rd_mux : 8'h00;
      bus_ready_r   <= bus_ok;
      irq_flag_r    <= any_irq_flag;
      second_tick_r <= upd;
    end

endmodule // rtc_time_calendar_alarm_bank

// File: dv/host_bus_model.sv
// host processor model on the byte register port
`timescale 1ns/1ps
module host_bus_model
(
  // clock
  input  logic       sys_clk,
  // byte register port
  output logic [6:0] bus_addr,
  output logic       bus_wr,
  output logic       bus_rd,
  output logic [7:0] bus_wdata,
  input  logic [7:0] bus_rdata_r
);
  initial
  begin
    bus_addr = 7'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
  end

  // ========
  // one-cycle strobes; idle data parked inverted
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    bus_wdata <= ~d;
  endtask

  task rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata_r;
  endtask
endmodule // host_bus_model

// File: dv/rtc_bank_sva.sv
// assertion checker for the rtc bank ports
`timescale 1ns/1ps
module rtc_bank_sva
(
  // clock and reset
  input logic       sys_clk,
  input logic       rst_n,
  // supply
  input logic       vcc_ok,
  // byte port
  input logic [6:0] bus_addr,
  input logic       bus_rd,
  input logic [7:0] bus_rdata_r,
  input logic       bus_ready_r,
  // status
  input logic       irq_flag_r,
  input logic       second_tick_r
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // ========
  // assertions
  a_tick_pulse: assert property (
    second_tick_r |=> !second_tick_r [*8])
    else $error("second tick too long");
  a_rdata_idle: assert property (
    !$past(bus_rd) |-> bus_rdata_r == 8'h00)
    else $error("read data without read");
  a_low_supply: assert property (
    !vcc_ok [*4] |-> !bus_ready_r)
    else $error("ready with supply low");
  a_read_refused: assert property (
    bus_rd ##1 !bus_ready_r |-> bus_rdata_r == 8'h00)
    else $error("refused read gave data");
  a_ready_cause: assert property (
    $rose(bus_ready_r) |-> $past(vcc_ok, 2))
    else $error("ready without supply");
  a_status_zero: assert property (
    bus_rd && bus_addr == 7'h0D |=> bus_rdata_r[6:0] == 7'h00)
    else $error("status low bits set");
  a_flags_zero: assert property (
    bus_rd && bus_addr == 7'h0C |=> bus_rdata_r[3:0] == 4'h0)
    else $error("flag low bits set");
  a_sec_top: assert property (
    bus_rd && bus_addr == 7'h00 |=> !bus_rdata_r[7])
    else $error("seconds top bit set");

  // ========
  // covers
  c_tick: cover property (second_tick_r);
  c_irq: cover property ($rose(irq_flag_r));
  c_ready: cover property ($rose(bus_ready_r));
endmodule // rtc_bank_sva

bind rtc_time_calendar_alarm_bank rtc_bank_sva chk
(
  .sys_clk(sys_clk), .rst_n(rst_n), .vcc_ok(vcc_ok),
  .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_rdata_r(bus_rdata_r),
  .bus_ready_r(bus_ready_r), .irq_flag_r(irq_flag_r),
  .second_tick_r(second_tick_r)
);

// File: dv/tb.sv
// testbench for the rtc time, calendar and alarm bank
`timescale 1ns/1ps
module tb;
  logic       sys_clk;
  logic       rst_n;
  logic       vcc_ok;
  logic       batt_ok;
  logic [6:0] bus_addr;
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata_r;
  logic       bus_ready_r;
  logic       irq_flag_r;
  logic       second_tick_r;
  logic [7:0] q;
  int         err_count;
  int         n_checks;
  int         cyc;

  // one divider step per clock keeps a second at 32768 cycles
  rtc_time_calendar_alarm_bank #(.CLK_HZ(32768), .REC_CYCLES(20)) dut
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .vcc_ok(vcc_ok), .batt_ok(batt_ok),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata_r(bus_rdata_r),
    .bus_ready_r(bus_ready_r), .irq_flag_r(irq_flag_r),
    .second_tick_r(second_tick_r)
  );

  host_bus_model host
  (
    .sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_r(bus_rdata_r)
  );

  // ========
  // shared checks
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("mismatch %s exp %h got %h", nm, e, g);
      err_count++;
    end
  endtask

  task rchk(input logic [6:0] a, input logic [7:0] e);
    host.rd(a, q);
    chk($sformatf("reg %h", a), e, q);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // load under inhibit, restart chain, judge the first update
  task run_day(input logic [7:0] b_set, input logic [7:0] b_run,
               input logic [7:0] ini [10], input logic [7:0] ex [10]);
    int n;
    host.wr(7'h0B, b_set);
    for (int i = 0; i < 10; i++)
      host.wr(i[6:0], ini[i]);
    host.wr(7'h0B, b_run);
    host.wr(7'h0A, 8'h60);
    host.wr(7'h0A, 8'h20);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    while (second_tick_r !== 1'b1 && n < 20000);
    chk("half second", 8'h01, {7'h00, n > 16370 && n < 16400});
    repeat (2) @(posedge sys_clk);
    #1;
    chk("irq", 8'h01, {7'h00, irq_flag_r});
    // read right after the tick, far from the next update
    for (int i = 0; i < 10; i++)
      rchk(i[6:0], ex[i]);
    rchk(7'h0C, 8'hB0);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("irq", 8'h00, {7'h00, irq_flag_r});
  endtask

  // ========
  // scenarios
  task t_power_up;
    repeat (8) @(posedge sys_clk);
    #1;
    chk("ready", 8'h00, {7'h00, bus_ready_r});
    rchk(7'h0A, 8'h00);
    @(posedge sys_clk) vcc_ok <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    chk("ready", 8'h01, {7'h00, bus_ready_r});
    rchk(7'h0A, 8'h20);
    $display("test power_up done");
  endtask

  task t_map;
    host.wr(7'h0C, 8'hFF);
    host.wr(7'h0D, 8'hFF);
    host.wr(7'h0A, 8'hA5);
    host.wr(7'h00, 8'h80);
    host.wr(7'h20, 8'h5A);
    host.wr(7'h32, 8'h19);
    rchk(7'h0C, 8'h00);
    rchk(7'h0D, 8'h80);
    rchk(7'h0A, 8'h25);
    rchk(7'h00, 8'h00);
    rchk(7'h20, 8'h5A);
    rchk(7'h32, 8'h19);
    $display("test map done");
  endtask

  task t_bcd_roll;
    logic [7:0] ini [10];
    logic [7:0] ex [10];
    ini = '{8'h59, 8'hC0, 8'h59, 8'hC0, 8'h23, 8'hC0, 8'h07, 8'h28,
            8'h02, 8'h24};
    ex = '{8'h00, 8'hC0, 8'h00, 8'hC0, 8'h00, 8'hC0, 8'h01, 8'h29,
           8'h02, 8'h24};
    run_day(8'h82, 8'h22, ini, ex);
    $display("test bcd_roll done");
  endtask

  task t_bin_12h;
    logic [7:0] ini [10];
    logic [7:0] ex [10];
    ini = '{8'h3B, 8'h00, 8'h3B, 8'h00, 8'h8B, 8'h0C, 8'h03, 8'h1E,
            8'h04, 8'h3F};
    ex = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h0C, 8'h04, 8'h01,
           8'h05, 8'h3F};
    run_day(8'h84, 8'h24, ini, ex);
    $display("test bin_12h done");
  endtask

  task t_recovery;
    @(posedge sys_clk) vcc_ok <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rchk(7'h20, 8'h00);
    @(posedge sys_clk) vcc_ok <= 1'b1;
    // first twelve cycles after supply return, the rise cycle included
    repeat (12)
    begin
      @(posedge sys_clk);
      #1;
      chk("ready", 8'h00, {7'h00, bus_ready_r});
    end
    repeat (30) @(posedge sys_clk);
    #1;
    chk("ready", 8'h01, {7'h00, bus_ready_r});
    rchk(7'h20, 8'h5A);
    $display("test recovery done");
  endtask

  // ========
  // clock, timeout and main sequence
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      final_report;
    end
  end

  initial
  begin
    rst_n = 1'b0;
    vcc_ok = 1'b0;
    batt_ok = 1'b1;
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_power_up;
    t_map;
    t_bcd_roll;
    t_bin_12h;
    t_recovery;
    final_report;
  end
endmodule // tb
